// ---- roc_pkg.sv ----
// Purpose: shared constants and types for the relay output command logic
// Assumes: 32 relays, avalon-mm slave with 32-bit data and word addressing
// Notes:   register indices are word addresses on the slave port
package roc_pkg;

	localparam int NRLY = 32;
	localparam int AW   = 4;

	// word addresses
	localparam logic [AW-1:0] REG_MODE_LO  = 4'h0;
	localparam logic [AW-1:0] REG_MODE_HI  = 4'h1;
	localparam logic [AW-1:0] REG_FAILSAFE = 4'h2;
	localparam logic [AW-1:0] REG_RETAIN   = 4'h3;
	localparam logic [AW-1:0] REG_WIDTH    = 4'h4;
	localparam logic [AW-1:0] REG_REM_OP   = 4'h5;
	localparam logic [AW-1:0] REG_REM_REL  = 4'h6;
	localparam logic [AW-1:0] REG_STATE    = 4'h7;
	localparam logic [AW-1:0] REG_HOLD     = 4'h8;
	localparam logic [AW-1:0] REG_LATCH    = 4'h9;
	localparam logic [AW-1:0] REG_COIL     = 4'hA;

	localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
	localparam int          WIDTH_RST   = 1;
	localparam int          WIDTH_MIN   = 1;

	// relay operating modes
	typedef enum logic [1:0] {
		MODE_UNLATCH = 2'b00,
		MODE_LATCH   = 2'b01,
		MODE_PULSE   = 2'b10,
		MODE_TOGGLE  = 2'b11
	} roc_mode_t;

	// pulse and toggle sequencing
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_ON   = 2'b01,
		PH_HOLD = 2'b10
	} roc_phase_t;

	typedef struct packed {
		logic          read;
		logic          write;
		logic [AW-1:0] address;
		logic [31:0]   writedata;
		logic [3:0]    byteenable;
	} roc_avs_req_t;

	typedef struct packed {
		logic        waitrequest;
		logic [31:0] readdata;
	} roc_avs_rsp_t;

endpackage : roc_pkg

// ---- roc_relay_cmd.sv ----
// Purpose: command logic for up to 32 output relays with avalon-mm registers
// Assumes: scan tick is a one-cycle strobe per half line cycle
// Notes:   relay state only moves on scan ticks; fault and power-up act at once
// Notes on behaviour
// - each relay has its own of four modes
// - failsafe inverts coil drive versus logical state
// - unlatched relay follows its linked setpoints
// - latched relay holds until explicit release
// - local release under remote hold clears latch only
// - pulse once, then hold released one width
// - width 10 ms to 1 s, excludes mechanics
// - evaluate on half-cycle tick, width whole ticks
// - toggle inverts state, then holds one width
// - internal pulse sources trigger pulse/toggle relays
// - remote operate holds latched/unlatched until release
// - remote release also clears local latch
// - pulse/toggle: remote operate triggers, release ignored
// - non-retentive relays restart inactive, remotes dropped
// - retentive latched relays keep state and remotes
// - critical fault releases all, clears remote commands
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module roc_relay_cmd #(
	parameter int TW = 8
) (
	// clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	// avalon-mm slave
	input  wire roc_pkg::roc_avs_req_t      avs_i,
	output roc_pkg::roc_avs_rsp_t           avs_o,
	// scan and system events
	input  wire logic                       scan_tick_i,
	input  wire logic                       crit_fault_i,
	input  wire logic                       pwr_restore_i,
	// local command sources
	input  wire logic [roc_pkg::NRLY-1:0]   setpoint_i,
	input  wire logic [roc_pkg::NRLY-1:0]   loc_release_i,
	input  wire logic [roc_pkg::NRLY-1:0]   pulse_src_i,
	// coil drivers
	output logic      [roc_pkg::NRLY-1:0]   coil_o
);
	import roc_pkg::*;

	typedef struct packed {
		logic                              wreq;
		logic [31:0]                       rdata;
		logic [NRLY-1:0][1:0]              mode;
		logic [NRLY-1:0]                   failsafe;
		logic [NRLY-1:0]                   retain;
		logic [TW-1:0]                     width;
		logic [NRLY-1:0]                   active;
		logic [NRLY-1:0]                   latch;
		logic [NRLY-1:0]                   hold;
		logic [NRLY-1:0]                   sp_prev;
		logic [NRLY-1:0]                   pend_op;
		logic [NRLY-1:0]                   pend_rel;
		logic [NRLY-1:0]                   pend_lrel;
		logic [NRLY-1:0]                   pend_src;
		roc_phase_t [NRLY-1:0]             phase;
		logic [NRLY-1:0][TW-1:0]           tmr;
		logic [NRLY-1:0]                   coil;
	} roc_state_t;

	roc_state_t s;
	roc_state_t next_s;

	// byte-lane merge for writable words
	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction : be_merge

	always_comb begin
		logic            req;
		logic            wr;
		logic [31:0]     new_op;
		logic [31:0]     new_rel;
		logic [TW-1:0]   w;
		logic            ev_op;
		logic            ev_rel;
		logic            ev_lrel;
		logic            ev_cmd;
		logic [NRLY-1:0] drop;
		req     = avs_i.read | avs_i.write;
		wr      = 1'b0;
		new_op  = '0;
		new_rel = '0;
		w       = '0;
		ev_op   = 1'b0;
		ev_rel  = 1'b0;
		ev_lrel = 1'b0;
		ev_cmd  = 1'b0;
		drop    = '0;
		next_s  = s;

		// one wait state: request seen with wreq high, answered next cycle
		next_s.wreq = ~(req & s.wreq);
		wr          = avs_i.write & ~s.wreq;
		if (req & s.wreq) begin
			unique case (avs_i.address)
				REG_MODE_LO:  next_s.rdata = s.mode[15:0];
				REG_MODE_HI:  next_s.rdata = s.mode[31:16];
				REG_FAILSAFE: next_s.rdata = s.failsafe;
				REG_RETAIN:   next_s.rdata = s.retain;
				REG_WIDTH:    next_s.rdata = 32'(s.width);
				REG_STATE:    next_s.rdata = s.active;
				REG_HOLD:     next_s.rdata = s.hold;
				REG_LATCH:    next_s.rdata = s.latch;
				REG_COIL:     next_s.rdata = s.coil;
				default:      next_s.rdata = RD_UNMAPPED;
			endcase
		end
		if (wr) begin
			unique case (avs_i.address)
				REG_MODE_LO:  next_s.mode[15:0]  = be_merge(s.mode[15:0],
					avs_i.writedata, avs_i.byteenable);
				REG_MODE_HI:  next_s.mode[31:16] = be_merge(s.mode[31:16],
					avs_i.writedata, avs_i.byteenable);
				REG_FAILSAFE: next_s.failsafe = be_merge(s.failsafe,
					avs_i.writedata, avs_i.byteenable);
				REG_RETAIN:   next_s.retain = be_merge(s.retain,
					avs_i.writedata, avs_i.byteenable);
				REG_WIDTH:    next_s.width = TW'(be_merge(32'(s.width),
					avs_i.writedata, avs_i.byteenable));
				REG_REM_OP:   new_op  = be_merge('0, avs_i.writedata, avs_i.byteenable);
				REG_REM_REL:  new_rel = be_merge('0, avs_i.writedata, avs_i.byteenable);
				default: ;
			endcase
		end

		// events between scans are kept; an event on the tick cycle is not lost
		// a tick-cycle event is used by that scan only, so it cannot outlive a later release
		next_s.pend_op   = scan_tick_i ? '0 : (s.pend_op | new_op);
		next_s.pend_rel  = scan_tick_i ? '0 : (s.pend_rel | new_rel);
		next_s.pend_lrel = scan_tick_i ? '0 : (s.pend_lrel | loc_release_i);
		next_s.pend_src  = scan_tick_i ? '0 : (s.pend_src | pulse_src_i);

		// zero width would give no pulse, so it is raised to one tick
		w = (s.width < TW'(WIDTH_MIN)) ? TW'(WIDTH_MIN) : s.width;

		// all relays evaluated together on the scan tick
		if (scan_tick_i) begin
			next_s.sp_prev = setpoint_i;
			for (int i = 0; i < NRLY; i++) begin
				ev_op   = s.pend_op[i] | new_op[i];
				ev_rel  = s.pend_rel[i] | new_rel[i];
				ev_lrel = s.pend_lrel[i] | loc_release_i[i];
				unique case (roc_mode_t'(s.mode[i]))
					MODE_UNLATCH, MODE_LATCH: begin
						next_s.phase[i] = PH_IDLE;
						next_s.tmr[i]   = '0;
						// remote hold, operate wins over release
						next_s.hold[i]  = ev_op | (s.hold[i] & ~ev_rel);
						if (roc_mode_t'(s.mode[i]) == MODE_LATCH) begin
							// local release drops latch, hold stays
							next_s.latch[i] = setpoint_i[i] |
								(s.latch[i] & ~(ev_lrel | ev_rel));
						end else begin
							next_s.latch[i] = 1'b0;
						end
						next_s.active[i] = next_s.latch[i] | next_s.hold[i] |
							(setpoint_i[i] & (roc_mode_t'(s.mode[i]) == MODE_UNLATCH));
					end
					MODE_PULSE, MODE_TOGGLE: begin
						next_s.latch[i] = 1'b0;
						next_s.hold[i]  = 1'b0;
						// remote operate triggers, remote release unused
						ev_cmd = ev_op | s.pend_src[i] | pulse_src_i[i] |
							(setpoint_i[i] & ~s.sp_prev[i]);
						unique case (s.phase[i])
							PH_IDLE: begin
								if (ev_cmd) begin
									next_s.tmr[i] = w;
									if (roc_mode_t'(s.mode[i]) == MODE_PULSE) begin
										next_s.active[i] = 1'b1;
										next_s.phase[i]  = PH_ON;
									end else begin
										next_s.active[i] = ~s.active[i];
										next_s.phase[i]  = PH_HOLD;
									end
								end
							end
							PH_ON: begin
								if (s.tmr[i] <= TW'(1)) begin
									// release and hold off one width
									next_s.active[i] = 1'b0;
									next_s.phase[i]  = PH_HOLD;
									next_s.tmr[i]    = w;
								end else begin
									next_s.tmr[i] = s.tmr[i] - TW'(1);
								end
							end
							PH_HOLD: begin
								// commands during hold-off are not accepted
								if (s.tmr[i] <= TW'(1)) begin
									next_s.phase[i] = PH_IDLE;
									next_s.tmr[i]   = '0;
								end else begin
									next_s.tmr[i] = s.tmr[i] - TW'(1);
								end
							end
							default: begin
								next_s.phase[i] = PH_IDLE;
								next_s.tmr[i]   = '0;
							end
						endcase
					end
				endcase
			end
		end

		// non-retentive relays restart inactive, remotes dropped
		if (pwr_restore_i) begin
			for (int i = 0; i < NRLY; i++) begin
				drop[i] = ~(s.retain[i] & (roc_mode_t'(s.mode[i]) == MODE_LATCH));
			end
		end
		if (crit_fault_i) begin
			drop = '1;
		end
		next_s.active    = next_s.active & ~drop;
		next_s.latch     = next_s.latch & ~drop;
		next_s.hold      = next_s.hold & ~drop;
		next_s.pend_op   = next_s.pend_op & ~drop;
		next_s.pend_rel  = next_s.pend_rel & ~drop;
		next_s.pend_src  = next_s.pend_src & ~drop;
		next_s.pend_lrel = next_s.pend_lrel & ~drop;
		for (int i = 0; i < NRLY; i++) begin
			if (drop[i]) begin
				next_s.phase[i] = PH_IDLE;
				next_s.tmr[i]   = '0;
			end
		end

		// failsafe energises the coil while inactive
		next_s.coil = next_s.active ^ next_s.failsafe;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s       <= '0;
			s.wreq  <= 1'b1;
			s.width <= TW'(WIDTH_RST);
		end else begin
			s <= next_s;
		end
	end

	assign avs_o.waitrequest = s.wreq;
	assign avs_o.readdata    = s.rdata;
	assign coil_o            = s.coil;

endmodule : roc_relay_cmd

// ---- roc_chk.sv ----
// Purpose: port-level checks for roc_relay_cmd
// Assumes: failsafe word is written with all byte lanes
// Notes: mirrors only the failsafe word
`timescale 1ns/10ps
module roc_chk
	import roc_pkg::*;
#(
	parameter int TW = 8
) (
	// clock, reset and bus
	input wire logic			clk_i,
	input wire logic			rst_i,
	input wire roc_pkg::roc_avs_req_t	avs_i,
	input wire roc_pkg::roc_avs_rsp_t	avs_o,
	// events, commands and coil drive
	input wire logic			scan_tick_i,
	input wire logic			crit_fault_i,
	input wire logic			pwr_restore_i,
	input wire logic [31:0]			setpoint_i,
	input wire logic [31:0]			loc_release_i,
	input wire logic [31:0]			pulse_src_i,
	input wire logic [31:0]			coil_o
);
	logic [31:0]	fs;
	logic		ack;
	logic		req;
	assign ack = !avs_o.waitrequest;
	assign req = avs_i.read || avs_i.write;
	// partial-lane failsafe writes are mirrored as the whole writedata word, byteenable ignored
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fs <= '0;
		end else if (avs_i.write && ack && avs_i.address == REG_FAILSAFE) begin
			fs <= avs_i.writedata;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	bus_answer_a: assert property (req && !ack |=> ack)
		else $error("no answer after one wait state");
	bus_single_a: assert property (ack |=> !ack)
		else $error("waitrequest low two cycles");
	bus_idle_a: assert property (!req && !ack |=> !ack)
		else $error("answer without request");
	unmapped_rd_a: assert property (avs_i.read && ack && avs_i.address > REG_COIL
		|-> avs_o.readdata == RD_UNMAPPED) else $error("unmapped read not zero");
	fs_read_a: assert property (avs_i.read && ack && avs_i.address == REG_FAILSAFE
		|-> avs_o.readdata == fs) else $error("failsafe readback wrong");
	coil_read_a: assert property (avs_i.read && ack && avs_i.address == REG_COIL
		&& $stable(coil_o) |-> avs_o.readdata == coil_o) else $error("coil readback wrong");
	tick_only_a: assert property (!scan_tick_i && !crit_fault_i && !pwr_restore_i
		&& !req |=> $stable(coil_o)) else $error("coil moved between ticks");
	fault_rel_a: assert property (crit_fault_i |=> coil_o == fs)
		else $error("fault did not release coils");
	fault_scan_a: assert property (crit_fault_i ##1 (scan_tick_i && !(|setpoint_i)
		&& !(|pulse_src_i) && !(avs_i.write && ack)) |=> coil_o == fs)
		else $error("relay active after fault");
	cover property (crit_fault_i);
	cover property (scan_tick_i ##1 !$stable(coil_o));
	cover property (avs_i.read && ack && avs_i.address > REG_COIL);
endmodule : roc_chk
bind roc_relay_cmd roc_chk #(.TW(TW)) roc_chk_i (
	.clk_i(clk_i), .rst_i(rst_i), .avs_i(avs_i), .avs_o(avs_o),
	.scan_tick_i(scan_tick_i), .crit_fault_i(crit_fault_i), .pwr_restore_i(pwr_restore_i),
	.setpoint_i(setpoint_i), .loc_release_i(loc_release_i), .pulse_src_i(pulse_src_i),
	.coil_o(coil_o)
);

// ---- roc_coil_model.sv ----
// Purpose: relay coil and contact model
// Assumes: fixed operate delay in clocks
// Notes: contact lag is kept outside the programmed width
`timescale 1ns/10ps
module roc_coil_model #(
	parameter int OP_CYC = 2
) (
	input  wire logic	 clk_i,
	input  wire logic [31:0] coil_i,
	output logic      [31:0] contact_o
);
	logic [31:0] dly [OP_CYC];
	always_ff @(posedge clk_i) begin
		dly[0] <= coil_i;
		for (int k = 1; k < OP_CYC; k++) begin
			dly[k] <= dly[k-1];
		end
	end
	assign contact_o = dly[OP_CYC-1];
endmodule : roc_coil_model

// ---- roc_relay_cmd_tb.sv ----
// Purpose: self-checking bench for roc_relay_cmd
// Assumes: pulse width set to 2 ticks
// Notes: bench stands in for the remote command source
`timescale 1ns/10ps
module roc_relay_cmd_tb;
	import roc_pkg::*;
	logic		clk_i = 1'b0;
	logic		rst_i = 1'b1;
	roc_avs_req_t	avs_i = '0;
	roc_avs_rsp_t	avs_o;
	logic		scan_tick_i = 1'b0;
	logic		crit_fault_i = 1'b0;
	logic		pwr_restore_i = 1'b0;
	logic [31:0]	setpoint_i = '0;
	logic [31:0]	loc_release_i = '0;
	logic [31:0]	pulse_src_i = '0;
	logic [31:0]	coil_o;
	logic [31:0]	contact;
	int		n_errors = 0;
	int		checks = 0;
	always #5 clk_i = ~clk_i;
	roc_relay_cmd #(.TW(8)) roc_relay_cmd_i (.clk_i(clk_i), .rst_i(rst_i), .avs_i(avs_i),
		.avs_o(avs_o), .scan_tick_i(scan_tick_i), .crit_fault_i(crit_fault_i),
		.pwr_restore_i(pwr_restore_i), .setpoint_i(setpoint_i),
		.loc_release_i(loc_release_i), .pulse_src_i(pulse_src_i), .coil_o(coil_o));
	roc_coil_model roc_coil_model_i (.clk_i(clk_i), .coil_i(coil_o), .contact_o(contact));
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		avs_i <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hf};
		@(posedge clk_i);
		// only the watchdog ends a wait that never gets an answer
		while (avs_o.waitrequest !== 1'b0) begin
			@(posedge clk_i);
		end
		q = avs_o.readdata;
		avs_i.read <= 1'b0;
		avs_i.write <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input string nm, input logic [3:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(nm, q, e);
	endtask : rd
	task automatic tick(input int n);
		repeat (n) begin
			scan_tick_i <= 1'b1;
			@(posedge clk_i);
			scan_tick_i <= 1'b0;
			@(posedge clk_i);
		end
	endtask : tick
	task automatic cc(input int i, input logic e);
		chk("coil", {31'h0, coil_o[i]}, {31'h0, e});
	endtask : cc
	task automatic pul(input logic src, input int i);
		pulse_src_i[i] <= src;
		loc_release_i[i] <= !src;
		@(posedge clk_i);
		pulse_src_i[i] <= 1'b0;
		loc_release_i[i] <= 1'b0;
	endtask : pul
	task automatic summarize();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd("width", REG_WIDTH, 32'h0000_0001);
		rd("unmapped", 4'hf, RD_UNMAPPED);
		wr(REG_MODE_HI, 32'hc000_0000);
		rd("mode_hi", REG_MODE_HI, 32'hc000_0000);
		setpoint_i[0] <= 1'b1;
		tick(1);
		cc(0, 1'b1);
		setpoint_i[0] <= 1'b0;
		tick(1);
		cc(0, 1'b0);
		wr(REG_REM_OP, 32'h0000_0002);
		tick(2);
		cc(1, 1'b1);
		wr(REG_REM_REL, 32'h0000_0002);
		tick(1);
		cc(1, 1'b0);
		wr(REG_MODE_LO, 32'h0000_0010);
		setpoint_i[2] <= 1'b1;
		tick(1);
		setpoint_i[2] <= 1'b0;
		tick(1);
		cc(2, 1'b1);
		pul(1'b0, 2);
		tick(1);
		cc(2, 1'b0);
		wr(REG_REM_OP, 32'h0000_0004);
		setpoint_i[2] <= 1'b1;
		tick(1);
		setpoint_i[2] <= 1'b0;
		pul(1'b0, 2);
		tick(1);
		cc(2, 1'b1);
		rd("latch", REG_LATCH, 32'h0000_0000);
		setpoint_i[2] <= 1'b1;
		tick(1);
		setpoint_i[2] <= 1'b0;
		wr(REG_REM_REL, 32'h0000_0004);
		tick(1);
		cc(2, 1'b0);
		wr(REG_WIDTH, 32'h0000_0002);
		wr(REG_MODE_LO, 32'h0000_0390);
		wr(REG_REM_OP, 32'h0000_0008);
		tick(2);
		cc(3, 1'b1);
		tick(1);
		cc(3, 1'b0);
		wr(REG_REM_OP, 32'h0000_0008);
		tick(2);
		cc(3, 1'b0);
		wr(REG_REM_OP, 32'h0000_0008);
		tick(1);
		wr(REG_REM_REL, 32'h0000_0008);
		tick(1);
		cc(3, 1'b1);
		pul(1'b1, 4);
		tick(1);
		cc(4, 1'b1);
		pul(1'b1, 4);
		tick(2);
		cc(4, 1'b1);
		pul(1'b1, 4);
		tick(1);
		cc(4, 1'b0);
		wr(REG_FAILSAFE, 32'h0000_0020);
		tick(1);
		cc(5, 1'b1);
		setpoint_i[5] <= 1'b1;
		tick(1);
		cc(5, 1'b0);
		setpoint_i[5] <= 1'b0;
		wr(REG_RETAIN, 32'h0000_0004);
		wr(REG_REM_OP, 32'h0000_0006);
		tick(1);
		pwr_restore_i <= 1'b1;
		@(posedge clk_i);
		pwr_restore_i <= 1'b0;
		tick(1);
		cc(1, 1'b0);
		cc(2, 1'b1);
		crit_fault_i <= 1'b1;
		@(posedge clk_i);
		crit_fault_i <= 1'b0;
		tick(1);
		chk("all", coil_o, 32'h0000_0020);
		rd("failsafe", REG_FAILSAFE, 32'h0000_0020);
		rd("coil_reg", REG_COIL, 32'h0000_0020);
		chk("contact", contact, 32'h0000_0020);
		summarize();
	end
	// the whole run needs well under a thousand clocks
	initial begin
		#100000;
		n_errors++;
		summarize();
	end
endmodule : roc_relay_cmd_tb
